// ==== res_defs.svh ====
`ifndef RES_DEFS_SVH
`define RES_DEFS_SVH

// Register byte offsets
`define RES_OFS_CTRL 8'h00
`define RES_OFS_FIXED 8'h04
`define RES_OFS_LONG 8'h08
`define RES_OFS_SWEEP 8'h0c
`define RES_OFS_LIMITS 8'h10
`define RES_OFS_STATUS 8'h14

// Control register fields
`define RES_CTRL_OVERRIDE_BIT 0
`define RES_CTRL_MODE_LSB 1
// Sweep register fields
`define RES_SWEEP_UPPER_LSB 0
`define RES_SWEEP_OFFSET_LSB 4
`define RES_SWEEP_SIGN_BIT 8

// Reset values
`define RES_RST_UPPER 4'h8
`define RES_RST_LIMIT 8'h40
`define RES_RST_FIXED 16'h0000
`define RES_RST_LONG 8'h00

// Bus answers
`define RES_RESP_OKAY 2'h0
`define RES_RESP_SLVERR 2'h2

// Settle time per trial setting
`define RES_SETTLE_NS 1000
`define RES_CLK_NS 10
`define RES_SETTLE_CYC ((`RES_SETTLE_NS + `RES_CLK_NS - 1) / `RES_CLK_NS)

`define RES_MAX_INDEX 4'hf

`endif

// ==== res_pkg.sv ====
`default_nettype none
package res_pkg;

  typedef enum logic [1:0] {
    RES_MODE_FIXED = 2'b00,
    RES_MODE_FAST = 2'b01,
    RES_MODE_FULL = 2'b10,
    RES_MODE_RSVD = 2'b11
  } res_mode_t;

  typedef enum logic [1:0] {
    RES_AD_IDLE = 2'b00,
    RES_AD_SETTLE = 2'b01,
    RES_AD_JUDGE = 2'b10
  } res_ad_state_t;

endpackage
`default_nettype wire

// ==== res_adapt_if.sv ====
`default_nettype none
interface res_adapt_if;
  logic start;
  logic full_mode;
  logic [3:0] upper;
  logic [3:0] offset;
  logic sign;
  logic [7:0] limit;
  logic [3:0] fixed_set;
  logic [3:0] long_set;
  logic [7:0] eye_height;
  logic [3:0] setting;
  logic busy;
  logic done;
  logic short_ch;

  modport eng (
    input start, full_mode, upper, offset, sign, limit, fixed_set, long_set, eye_height,
    output setting, busy, done, short_ch
  );
  modport ctl (
    output start, full_mode, upper, offset, sign, limit, fixed_set, long_set, eye_height,
    input setting, busy, done, short_ch
  );
endinterface
`default_nettype wire

// ==== res_strap_sample.sv ====
`include "res_defs.svh"
`default_nettype none
module res_strap_sample (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable_pin,
  input wire logic [1:0] conn_strap_high,
  input wire logic [1:0] conn_strap_low,
  input wire logic [1:0] host_strap_high,
  input wire logic [1:0] host_strap_low,
  input wire logic adaptive_disable_strap,
  input wire logic pin_strap_mode,
  output logic [3:0] conn_index,
  output logic [3:0] host_index,
  output logic adapt_disabled,
  output logic strap_mode,
  output logic sampled
);
  import res_pkg::*;

  typedef struct packed {
    logic [10:0] s1;
    logic [10:0] s2;
    logic en_d;
    logic [3:0] conn_idx;
    logic [3:0] host_idx;
    logic adis;
    logic pmode;
    logic done;
  } res_strap_state_t;

  res_strap_state_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = {enable_pin, conn_strap_high, conn_strap_low, host_strap_high,
                  host_strap_low, adaptive_disable_strap, pin_strap_mode};
    st_next.s2 = st_reg.s1;
    st_next.en_d = st_reg.s2[10];
    // Capture once per enable rise; levels hold afterwards
    if (st_reg.s2[10] && !st_reg.en_d) begin
      st_next.conn_idx = {st_reg.s2[9:8], st_reg.s2[7:6]};
      st_next.host_idx = {st_reg.s2[5:4], st_reg.s2[3:2]};
      st_next.adis = st_reg.s2[1];
      st_next.pmode = st_reg.s2[0];
      st_next.done = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign conn_index = st_reg.conn_idx;
  assign host_index = st_reg.host_idx;
  assign adapt_disabled = st_reg.adis;
  assign strap_mode = st_reg.pmode;
  assign sampled = st_reg.done;
endmodule
`default_nettype wire

// ==== res_adapt_engine.sv ====
`include "res_defs.svh"
`default_nettype none
module res_adapt_engine #(
  parameter int SETTLE_CYC = `RES_SETTLE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  res_adapt_if.eng ad
);
  import res_pkg::*;

  localparam int CW = $clog2(SETTLE_CYC + 1);

  typedef struct packed {
    res_ad_state_t st;
    logic [3:0] idx;
    logic [3:0] best;
    logic [7:0] best_eye;
    logic [CW-1:0] cnt;
    logic [3:0] result;
    logic busy;
    logic done;
    logic short_ch;
  } res_eng_state_t;

  res_eng_state_t e_reg, e_next;
  logic [4:0] sum;

  always_comb begin
    e_next = e_reg;
    sum = {1'b0, e_reg.best} + {1'b0, ad.offset};
    unique case (e_reg.st)
      RES_AD_IDLE: begin
        if (ad.start) begin
          e_next.idx = ad.full_mode ? 4'h0 : ad.fixed_set;
          e_next.best = 4'h0;
          e_next.best_eye = 8'h00;
          e_next.cnt = '0;
          e_next.busy = 1'b1;
          e_next.done = 1'b0;
          e_next.st = RES_AD_SETTLE;
        end
      end
      RES_AD_SETTLE: begin
        e_next.cnt = e_reg.cnt + CW'(1);
        if (e_reg.cnt == CW'(SETTLE_CYC - 1)) begin
          e_next.st = RES_AD_JUDGE;
        end
      end
      RES_AD_JUDGE: begin
        if (ad.full_mode) begin
          if (e_reg.idx == 4'h0 || ad.eye_height > e_reg.best_eye) begin
            e_next.best = e_reg.idx;
            e_next.best_eye = ad.eye_height;
          end
          // Last step judged next cycle is not needed: finish here
          if (e_reg.idx >= ad.upper || e_reg.idx == `RES_MAX_INDEX) begin
            e_next.st = RES_AD_IDLE;
            e_next.busy = 1'b0;
            e_next.done = 1'b1;
          end else begin
            e_next.idx = e_reg.idx + 4'h1;
            e_next.cnt = '0;
            e_next.st = RES_AD_SETTLE;
          end
        end else begin
          // Eye at or above limit means short channel
          e_next.short_ch = (ad.eye_height >= ad.limit);
          e_next.result = (ad.eye_height >= ad.limit) ? ad.fixed_set : ad.long_set;
          e_next.st = RES_AD_IDLE;
          e_next.busy = 1'b0;
          e_next.done = 1'b1;
        end
      end
      default: begin
        e_next.st = RES_AD_IDLE;
        e_next.busy = 1'b0;
      end
    endcase
    // Offset applied once the sweep has its best index
    if (e_reg.st == RES_AD_JUDGE && ad.full_mode && e_next.done) begin
      if (e_reg.idx == 4'h0 || ad.eye_height > e_reg.best_eye) begin
        sum = {1'b0, e_reg.idx} + {1'b0, ad.offset};
        if (!ad.sign) begin
          e_next.result = sum[4] ? `RES_MAX_INDEX : sum[3:0];
        end else begin
          e_next.result = (e_reg.idx < ad.offset) ? 4'h0 : e_reg.idx - ad.offset;
        end
      end else if (!ad.sign) begin
        e_next.result = sum[4] ? `RES_MAX_INDEX : sum[3:0];
      end else begin
        e_next.result = (e_reg.best < ad.offset) ? 4'h0 : e_reg.best - ad.offset;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      e_reg <= '0;
    end else begin
      e_reg <= e_next;
    end
  end

  assign ad.setting = e_reg.busy ? e_reg.idx : e_reg.result;
  assign ad.busy = e_reg.busy;
  assign ad.done = e_reg.done;
  assign ad.short_ch = e_reg.short_ch;
endmodule
`default_nettype wire

// ==== res_top.sv ====
// The register addresses and register access over AXI4-Lite were decided locally.
`include "res_defs.svh"
`default_nettype none
module res_top #(
  parameter int SETTLE_CYC = `RES_SETTLE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic enable_pin,
  input wire logic pin_strap_mode,
  input wire logic [1:0] conn_strap_high,
  input wire logic [1:0] conn_strap_low,
  input wire logic [1:0] host_strap_high,
  input wire logic [1:0] host_strap_low,
  input wire logic adaptive_disable_strap,
  input wire logic [1:0] adapt_start,
  input wire logic [7:0] conn_eye_height_lane1,
  input wire logic [7:0] conn_eye_height_lane2,
  output logic [3:0] conn_rx_lane1_setting,
  output logic [3:0] conn_rx_lane2_setting,
  output logic [3:0] host_rx_lane1_setting,
  output logic [3:0] host_rx_lane2_setting
);
  import res_pkg::*;

  typedef struct packed {
    logic aw_rdy;
    logic w_rdy;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic override;
    res_mode_t mode;
    logic [15:0] fixed;
    logic [7:0] long_set;
    logic [3:0] upper;
    logic [3:0] offset;
    logic sign;
    logic [7:0] limit;
    logic [15:0] out_set;
  } res_top_state_t;

  res_top_state_t r_reg, r_next;

  logic [3:0] strap_conn;
  logic [3:0] strap_host;
  logic strap_adis;
  logic strap_pmode;
  logic strap_done;
  logic [1:0] full_en;
  logic [1:0] fast_en;
  logic [1:0] eng_busy;
  logic [1:0] eng_done;
  logic [1:0] eng_short;
  logic [7:0] eng_setting;
  logic [31:0] ctrl_word;
  logic [31:0] sweep_word;
  logic [31:0] status_word;
  logic [31:0] merged;

  function automatic logic [31:0] res_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] v;
    v = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        v[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  res_strap_sample u_strap (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable_pin(enable_pin),
    .conn_strap_high(conn_strap_high),
    .conn_strap_low(conn_strap_low),
    .host_strap_high(host_strap_high),
    .host_strap_low(host_strap_low),
    .adaptive_disable_strap(adaptive_disable_strap),
    .pin_strap_mode(pin_strap_mode),
    .conn_index(strap_conn),
    .host_index(strap_host),
    .adapt_disabled(strap_adis),
    .strap_mode(strap_pmode),
    .sampled(strap_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // One adaptation engine per connector lane; host lanes have none
  for (genvar g = 0; g < 2; g++) begin : g_lane
    res_adapt_if ad_if ();
    assign ad_if.start = adapt_start[g] && (full_en[g] || fast_en[g]) && strap_done;
    assign ad_if.full_mode = full_en[g];
    assign ad_if.upper = r_reg.upper;
    assign ad_if.offset = r_reg.offset;
    assign ad_if.sign = r_reg.sign;
    assign ad_if.limit = r_reg.limit;
    assign ad_if.fixed_set = r_reg.fixed[g*4 +: 4];
    assign ad_if.long_set = r_reg.long_set[g*4 +: 4];
    assign ad_if.eye_height = (g == 0) ? conn_eye_height_lane1 : conn_eye_height_lane2;
    assign eng_setting[g*4 +: 4] = ad_if.setting;
    assign eng_busy[g] = ad_if.busy;
    assign eng_done[g] = ad_if.done;
    assign eng_short[g] = ad_if.short_ch;
    res_adapt_engine #(.SETTLE_CYC(SETTLE_CYC)) u_eng (
      .aclk(aclk),
      .aresetn(aresetn),
      .ad(ad_if.eng)
    );
    // Strap mode follows disable strap; register mode follows mode field
    assign full_en[g] = strap_pmode ? !strap_adis : (r_reg.mode == RES_MODE_FULL);
    // Two-choice needs programmed fields, hence override and register mode
    assign fast_en[g] = !strap_pmode && r_reg.override && (r_reg.mode == RES_MODE_FAST);
  end

  ////////////////////////////////////////////////////////////////////////////
  assign ctrl_word = {29'h0, r_reg.mode, r_reg.override};
  assign sweep_word = {23'h0, r_reg.sign, r_reg.offset, r_reg.upper};
  assign status_word = {8'h0, strap_done, strap_pmode, eng_short, eng_done, eng_busy,
                        r_reg.out_set};

  always_comb begin
    r_next = r_reg;
    merged = 32'h0;

    // Write path: address and data taken in either order
    if (s_axi_awvalid && r_reg.aw_rdy) begin
      r_next.aw_got = 1'b1;
      r_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_reg.w_rdy) begin
      r_next.w_got = 1'b1;
      r_next.wdata = s_axi_wdata;
      r_next.wstrb = s_axi_wstrb;
    end
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = `RES_RESP_OKAY;
      unique case (r_reg.awaddr)
        `RES_OFS_CTRL: begin
          merged = res_merge(ctrl_word, r_reg.wdata, r_reg.wstrb);
          r_next.override = merged[`RES_CTRL_OVERRIDE_BIT];
          r_next.mode = res_mode_t'(merged[`RES_CTRL_MODE_LSB +: 2]);
        end
        `RES_OFS_FIXED: begin
          merged = res_merge({16'h0, r_reg.fixed}, r_reg.wdata, r_reg.wstrb);
          r_next.fixed = merged[15:0];
        end
        `RES_OFS_LONG: begin
          merged = res_merge({24'h0, r_reg.long_set}, r_reg.wdata, r_reg.wstrb);
          r_next.long_set = merged[7:0];
        end
        `RES_OFS_SWEEP: begin
          merged = res_merge(sweep_word, r_reg.wdata, r_reg.wstrb);
          r_next.upper = merged[`RES_SWEEP_UPPER_LSB +: 4];
          r_next.offset = merged[`RES_SWEEP_OFFSET_LSB +: 4];
          r_next.sign = merged[`RES_SWEEP_SIGN_BIT];
        end
        `RES_OFS_LIMITS: begin
          merged = res_merge({24'h0, r_reg.limit}, r_reg.wdata, r_reg.wstrb);
          r_next.limit = merged[7:0];
        end
        // Status is read only; writes ignored with OKAY
        `RES_OFS_STATUS: begin
          r_next.bresp = `RES_RESP_OKAY;
        end
        default: begin
          r_next.bresp = `RES_RESP_SLVERR;
        end
      endcase
    end
    r_next.aw_rdy = !r_next.aw_got && !r_next.bvalid;
    r_next.w_rdy = !r_next.w_got && !r_next.bvalid;

    // Read path: one outstanding read
    if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r_reg.ar_rdy) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = `RES_RESP_OKAY;
      unique case (s_axi_araddr)
        `RES_OFS_CTRL: r_next.rdata = ctrl_word;
        `RES_OFS_FIXED: r_next.rdata = {16'h0, r_reg.fixed};
        `RES_OFS_LONG: r_next.rdata = {24'h0, r_reg.long_set};
        `RES_OFS_SWEEP: r_next.rdata = sweep_word;
        `RES_OFS_LIMITS: r_next.rdata = {24'h0, r_reg.limit};
        `RES_OFS_STATUS: r_next.rdata = status_word;
        default: begin
          r_next.rdata = 32'h0;
          r_next.rresp = `RES_RESP_SLVERR;
        end
      endcase
    end
    r_next.ar_rdy = !r_next.rvalid;

    // Setting selection per lane
    for (int l = 0; l < 2; l++) begin
      // Host lanes: fixed field under override in register mode, else own straps
      if (!strap_pmode && r_reg.override) begin
        r_next.out_set[8 + l*4 +: 4] = r_reg.fixed[8 + l*4 +: 4];
      end else begin
        r_next.out_set[8 + l*4 +: 4] = strap_host;
      end
      // Connector lanes: engine setting once an engine has started (trial index while busy, result when done)
      if ((full_en[l] || fast_en[l]) && (eng_busy[l] || eng_done[l])) begin
        r_next.out_set[l*4 +: 4] = eng_setting[l*4 +: 4];
      end else if (!strap_pmode && r_reg.override) begin
        r_next.out_set[l*4 +: 4] = r_reg.fixed[l*4 +: 4];
      end else begin
        r_next.out_set[l*4 +: 4] = strap_conn;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
      r_reg.upper <= `RES_RST_UPPER;
      r_reg.limit <= `RES_RST_LIMIT;
      r_reg.fixed <= `RES_RST_FIXED;
      r_reg.long_set <= `RES_RST_LONG;
      r_reg.mode <= RES_MODE_FIXED;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = r_reg.aw_rdy;
  assign s_axi_wready = r_reg.w_rdy;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_arready = r_reg.ar_rdy;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rdata = r_reg.rdata;
  assign s_axi_rresp = r_reg.rresp;
  assign conn_rx_lane1_setting = r_reg.out_set[3:0];
  assign conn_rx_lane2_setting = r_reg.out_set[7:4];
  assign host_rx_lane1_setting = r_reg.out_set[11:8];
  assign host_rx_lane2_setting = r_reg.out_set[15:12];
endmodule
`default_nettype wire

// ==== res_top_assertions.sv ====
`default_nettype none
module res_top_checker #(
  parameter int SETTLE_CYC = 100
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] adapt_start,
  input wire logic [3:0] host_rx_lane1_setting,
  input wire logic [3:0] host_rx_lane2_setting
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_late;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  wr_resp_time_a: assert property (wr_taken |=> b_late)
    else $error("write answer not two cycles after request");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  rd_resp_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  wr_reopen_a: assert property (s_axi_bvalid && s_axi_bready |->
    ##[1:2] (s_axi_awready && s_axi_wready)) else $error("write channel stays closed");
  host_fixed_a: assert property (|adapt_start |=>
    ($stable(host_rx_lane1_setting) && $stable(host_rx_lane2_setting)) || $past(s_axi_bvalid))
    else $error("host lane moved on adaptation start");
endmodule
`default_nettype wire

// ==== res_eye_model.sv ====
`default_nettype none
module res_eye_model #(
  parameter logic [3:0] PEAK1 = 4'h5,
  parameter logic [3:0] PEAK2 = 4'h3
) (
  input wire logic [3:0] set1,
  input wire logic [3:0] set2,
  input wire logic chan_long,
  output logic [7:0] eye1,
  output logic [7:0] eye2
);
  timeunit 1ns;
  timeprecision 1ps;
  // Eye peaks at one setting, drops 0x10 a step; a cable costs 0xc0
  function automatic logic [7:0] eye_of(input logic [3:0] s, input logic [3:0] pk,
                                        input logic lg);
    int e;
    e = 32'h00f0 - 32'h0010 * ((s > pk) ? int'(s - pk) : int'(pk - s));
    if (lg) e = e - 32'h00c0;
    return (e < 0) ? 8'h00 : 8'(e);
  endfunction
  assign eye1 = eye_of(set1, PEAK1, chan_long);
  assign eye2 = eye_of(set2, PEAK2, chan_long);
endmodule
`default_nettype wire

// ==== res_top_tb_top.sv ====
`default_nettype none
module res_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 4;
  localparam int LIMIT = 6000;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic enable_pin, pin_strap_mode, adaptive_disable_strap, chan_long;
  logic [7:0] s_axi_awaddr, s_axi_araddr, eye1, eye2;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, set_c1, set_c2, set_h1, set_h2;
  logic [1:0] s_axi_bresp, s_axi_rresp, adapt_start, csh, csl, hsh, hsl;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  res_top #(.SETTLE_CYC(SETTLE)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .enable_pin(enable_pin),
    .pin_strap_mode(pin_strap_mode), .conn_strap_high(csh), .conn_strap_low(csl),
    .host_strap_high(hsh), .host_strap_low(hsl), .adaptive_disable_strap(adaptive_disable_strap),
    .adapt_start(adapt_start), .conn_eye_height_lane1(eye1), .conn_eye_height_lane2(eye2),
    .conn_rx_lane1_setting(set_c1), .conn_rx_lane2_setting(set_c2),
    .host_rx_lane1_setting(set_h1), .host_rx_lane2_setting(set_h2));
  res_eye_model #(.PEAK1(4'h5), .PEAK2(4'h3)) eye (.set1(set_c1), .set2(set_c2),
    .chan_long(chan_long), .eye1(eye1), .eye2(eye2));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Hang guard
  always @(posedge aclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Trailing edge keeps back-to-back calls from driving a signal twice per step
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    r = 2'h3;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rexp);
    logic [31:0] d;
    logic [1:0] r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    d = 32'hdead_beef;
    r = 2'h3;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
    check(d, exp);
    check(r, rexp);
  endtask
  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    check(r, 32'h0);
  endtask
  task automatic chk_set(input logic [15:0] exp);
    check({16'h0, set_h2, set_h1, set_c2, set_c1}, {16'h0, exp});
  endtask
  task automatic pulse();
    adapt_start <= 2'b11;
    wait_cyc(1);
    adapt_start <= 2'b00;
  endtask
  task automatic boot(input logic md, input logic [7:0] straps);
    aresetn <= 1'b0;
    enable_pin <= 1'b0;
    pin_strap_mode <= md;
    {csh, csl, hsh, hsl} <= straps;
    wait_cyc(5);
    aresetn <= 1'b1;
    wait_cyc(3);
    enable_pin <= 1'b1;
    wait_cyc(10);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [1:0] r;
    rd_chk(8'h00, 32'h0, 2'h0);
    rd_chk(8'h0c, 32'h8, 2'h0);
    rd_chk(8'h10, 32'h40, 2'h0);
    rd_chk(8'h18, 32'h0, 2'h2);
    axi_wr(8'h18, 32'hffff_ffff, r);
    check(r, 32'h2);
    rd_chk(8'h04, 32'h0, 2'h0);
    $display("test regs done");
  endtask
  task automatic t_straps();
    logic [3:0] c, h;
    for (int i = 0; i < 4; i++) begin
      boot(1'b1, {i[1:0], 2'(3 - i), 2'(3 - i), i[1:0]});
      c = 4'(3 * i + 3);
      h = 4'(12 - 3 * i);
      chk_set({h, h, c, c});
    end
    {csh, csl, hsh, hsl} <= 8'h00;
    wait_cyc(10);
    chk_set({h, h, c, c});
    wr_ok(8'h00, 32'h3);
    pulse();
    wait_cyc(20);
    chk_set({h, h, c, c});
    adaptive_disable_strap <= 1'b0;
    boot(1'b1, 8'h00);
    pulse();
    wait_cyc(60);
    chk_set(16'h0035);
    adaptive_disable_strap <= 1'b1;
    $display("test straps done");
  endtask
  task automatic t_fixed();
    boot(1'b0, 8'h61);
    wr_ok(8'h04, 32'h0000_a5c3);
    wait_cyc(2);
    chk_set(16'h1166);
    wr_ok(8'h00, 32'h1);
    wait_cyc(2);
    chk_set(16'ha5c3);
    wr_ok(8'h00, 32'h7);
    wait_cyc(2);
    chk_set(16'ha5c3);
    rd_chk(8'h14, 32'h0080_a5c3, 2'h0);
    $display("test fixed done");
  endtask
  task automatic t_full();
    logic [11:0] sw [6] = '{12'h008, 12'h038, 12'h128, 12'h0f8, 12'h148, 12'h002};
    logic [7:0] ex [6] = '{8'h35, 8'h68, 8'h13, 8'hff, 8'h01, 8'h22};
    wr_ok(8'h00, 32'h5);
    for (int k = 0; k < 6; k++) begin
      wr_ok(8'h0c, {20'h0, sw[k]});
      pulse();
      wait_cyc(3);
      check(set_c1, 32'h0);
      wait_cyc(60);
      chk_set({8'ha5, ex[k]});
    end
    $display("test full done");
  endtask
  task automatic fast_case(input logic lg, input logic [15:0] exp);
    chan_long <= lg;
    wait_cyc(1);
    pulse();
    wait_cyc(15);
    chk_set(exp);
  endtask
  task automatic t_fast();
    wr_ok(8'h04, 32'h0000_a535);
    wr_ok(8'h08, 32'h0000_00c9);
    wr_ok(8'h00, 32'h3);
    fast_case(1'b0, 16'ha535);
    fast_case(1'b1, 16'ha5c9);
    wr_ok(8'h10, 32'hff);
    fast_case(1'b0, 16'ha5c9);
    $display("test fast done");
  endtask
  initial begin
    {aresetn, enable_pin, pin_strap_mode, chan_long} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {csh, csl, hsh, hsl, adapt_start} = 10'h000;
    adaptive_disable_strap = 1'b1;
    s_axi_wstrb = 4'hf;
    @(posedge aclk);
    boot(1'b0, 8'h00);
    t_regs();
    t_straps();
    t_fixed();
    t_full();
    t_fast();
    report_and_stop();
  end
endmodule
bind res_top res_top_checker #(.SETTLE_CYC(SETTLE_CYC)) chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .adapt_start(adapt_start),
  .host_rx_lane1_setting(host_rx_lane1_setting), .host_rx_lane2_setting(host_rx_lane2_setting));
`default_nettype wire
